// ===== hw/eps_pkg.sv
// shared constants, types and helpers for the program start link
package eps_pkg;

  // time base and documented minimum link timings
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int READY_TO_START_DELAY_MS = 10;
  localparam int SELECT_TO_START_DELAY_MS = 50;
  localparam int START_PULSE_WIDTH_MS = 100;
  localparam int READY_TO_START_DELAY_CYC = READY_TO_START_DELAY_MS * CYC_PER_MS;
  localparam int SELECT_TO_START_DELAY_CYC = SELECT_TO_START_DELAY_MS * CYC_PER_MS;
  localparam int START_PULSE_WIDTH_CYC = START_PULSE_WIDTH_MS * CYC_PER_MS;
  localparam int CNT_W = 24;

  // program number: three bcd digits, binary form up to 999
  localparam int DIGITS = 3;
  localparam int BCD_W = 4 * DIGITS;
  localparam int PROG_W = 10;
  localparam logic [PROG_W-1:0] PROG_MAX = 10'h3E7;

  // start-method setting codes
  localparam logic [1:0] METHOD_EXT = 2'h0;
  localparam logic [1:0] METHOD_AUTO = 2'h1;
  localparam logic [1:0] METHOD_EDGE = 2'h2;

  // sequencer register map (byte addresses) and fields
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PROG = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam int CTRL_GO = 0;
  localparam int CTRL_IN3 = 1;
  localparam int CTRL_ESTOP = 2;
  localparam int STAT_READY = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_REFUSED = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    DS_INIT = 2'b00,
    DS_READY = 2'b01,
    DS_RUN = 2'b10,
    DS_FAULT = 2'b11
  } eps_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_PULSE = 2'b10
  } eps_seq_state_t;

  // every digit must be 0..9
  function automatic logic eps_bcd_ok(input logic [BCD_W-1:0] b);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (b[4*i +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // bcd to binary, most significant digit first
  function automatic logic [PROG_W-1:0] eps_bcd_to_bin(input logic [BCD_W-1:0] b);
    logic [PROG_W+3:0] acc;
    acc = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      acc = (PROG_W+4)'(acc[PROG_W-1:0] * 10) + (PROG_W+4)'(b[4*i +: 4]);
    end
    return acc[PROG_W-1:0];
  endfunction

  // binary to bcd for values up to 999
  function automatic logic [BCD_W-1:0] eps_bin_to_bcd(input logic [PROG_W-1:0] v);
    logic [BCD_W-1:0] r;
    r[3:0] = 4'(v % 10);
    r[7:4] = 4'((v / 10) % 10);
    r[11:8] = 4'(v / 100);
    return r;
  endfunction

endpackage

// ===== hw/eps_link_if.sv
// discrete signals between the controller and the external sequencer
`timescale 1ns/100ps
`default_nettype none
interface eps_link_if
  import eps_pkg::*;
  ();
  logic ready;
  logic running;
  logic start;
  logic gp_in3;
  logic estop;
  logic [BCD_W-1:0] prog_bcd;

  modport dev (
    output ready,
    output running,
    input start,
    input gp_in3,
    input estop,
    input prog_bcd
  );

  modport seq (
    input ready,
    input running,
    output start,
    output gp_in3,
    output estop,
    output prog_bcd
  );
endinterface
`default_nettype wire

// ===== hw/eps_device.sv
// controller end: program start logic with ready, auto and external start
//
// The sequencer's APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module eps_device
  import eps_pkg::*;
  (
  input wire logic ref_clk,
  input wire logic rstn,
  eps_link_if.dev link,
  input wire logic [1:0] start_method,
  input wire logic auto_mode,
  input wire logic [PROG_W-1:0] auto_prog,
  input wire logic init_done,
  input wire logic ctrl_error,
  input wire logic prog_done,
  output logic servo_on,
  output logic ready_lamp,
  output logic [PROG_W-1:0] disp_prog,
  output logic run_prog,
  output logic run_start,
  output logic run_stop,
  output logic start_ignored,
  output logic bad_number
  );

  eps_dev_state_t state_r;
  eps_dev_state_t state_nxt;
  logic in3_q_r;
  logic start_q_r;
  logic in3_rise;
  logic in3_fall;
  logic start_rise;
  logic req;
  logic num_ok;
  logic take;
  logic term;
  logic ignore;
  logic reject;
  logic [PROG_W-1:0] sel_prog;
  logic ready_r;
  logic lamp_r;
  logic servo_r;
  logic run_r;
  logic run_start_r;
  logic run_stop_r;
  logic ignored_r;
  logic bad_r;
  logic [PROG_W-1:0] disp_r;

  // previous samples for edge detection; inputs are synchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in3_q_r <= 1'b0;
      start_q_r <= 1'b0;
    end else begin
      in3_q_r <= link.gp_in3;
      start_q_r <= link.start;
    end
  end

  assign in3_rise = link.gp_in3 & ~in3_q_r;
  assign in3_fall = ~link.gp_in3 & in3_q_r;
  assign start_rise = link.start & ~start_q_r;

  // a start request from whichever source the method selects
  always_comb begin
    case (start_method)
      METHOD_EDGE: req = in3_rise;
      METHOD_EXT: req = start_rise;
      default: req = 1'b0;
    endcase
  end

  // number is judged at the edge of the request itself
  assign num_ok = eps_bcd_ok(link.prog_bcd);

  // sequencing: faults win over everything else
  always_comb begin
    state_nxt = state_r;
    take = 1'b0;
    term = 1'b0;
    ignore = 1'b0;
    reject = 1'b0;
    sel_prog = disp_r;
    if (link.estop || ctrl_error) begin
      state_nxt = DS_FAULT;
      term = (state_r == DS_RUN);
      ignore = req;
    end else begin
      case (state_r)
        DS_INIT: begin
          ignore = req;
          if (init_done) begin
            if (auto_mode && start_method == METHOD_AUTO) begin
              state_nxt = DS_RUN;
              take = 1'b1;
              sel_prog = auto_prog;
            end else begin
              state_nxt = DS_READY;
            end
          end
        end
        DS_READY: begin
          if (req && num_ok) begin
            state_nxt = DS_RUN;
            take = 1'b1;
            sel_prog = eps_bcd_to_bin(link.prog_bcd);
          end else if (req) begin
            reject = 1'b1;
          end
        end
        DS_RUN: begin
          ignore = req;
          if (start_method == METHOD_EDGE && in3_fall) begin
            state_nxt = DS_READY;
            term = 1'b1;
          end else if (prog_done) begin
            state_nxt = DS_READY;
          end
        end
        DS_FAULT: begin
          ignore = req;
          state_nxt = DS_READY;
        end
        default: begin
          state_nxt = DS_INIT;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= DS_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ready and its lamp move together; no ready while faulted
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ready_r <= 1'b0;
      lamp_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == DS_READY);
      lamp_r <= (state_nxt == DS_READY);
    end
  end

  // servo power held off during init and while estop or ctrl_error is asserted
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      servo_r <= 1'b0;
    end else begin
      servo_r <= (state_nxt == DS_READY) || (state_nxt == DS_RUN);
    end
  end

  // run level and one-cycle start and stop strobes to the executor
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
      run_start_r <= 1'b0;
      run_stop_r <= 1'b0;
    end else begin
      run_r <= (state_nxt == DS_RUN);
      run_start_r <= take;
      run_stop_r <= term;
    end
  end

  // display keeps the last started number; latched only on a start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      disp_r <= '0;
    end else if (take) begin
      disp_r <= sel_prog;
    end
  end

  // diagnostics: request while not ready, or malformed bcd number
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ignored_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      ignored_r <= ignore;
      bad_r <= reject;
    end
  end

  assign link.ready = ready_r;
  assign link.running = run_r;
  assign servo_on = servo_r;
  assign ready_lamp = lamp_r;
  assign disp_prog = disp_r;
  assign run_prog = run_r;
  assign run_start = run_start_r;
  assign run_stop = run_stop_r;
  assign start_ignored = ignored_r;
  assign bad_number = bad_r;

endmodule
`default_nettype wire

// ===== hw/eps_sequencer.sv
// sequencer end: apb-controlled driver of program number and start pulse
`timescale 1ns/100ps
`default_nettype none
module eps_sequencer
  import eps_pkg::*;
  #(
  parameter int RDY_CYC = READY_TO_START_DELAY_CYC,
  parameter int SEL_CYC = SELECT_TO_START_DELAY_CYC,
  parameter int PULSE_CYC = START_PULSE_WIDTH_CYC
  )
  (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  eps_link_if.seq link
  );

  // counters are CNT_W wide; refuse figures they cannot hold
  if (RDY_CYC < 1 || SEL_CYC < 1 || PULSE_CYC < 1 ||
      RDY_CYC >= (1 << CNT_W) || SEL_CYC >= (1 << CNT_W) ||
      PULSE_CYC >= (1 << CNT_W)) begin : g_chk
    $error("eps_sequencer: timing count out of range");
  end

  eps_seq_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] rdy_cnt_r;
  logic [PROG_W-1:0] prog_r;
  logic [BCD_W-1:0] bcd_r;
  logic in3_r;
  logic estop_r;
  logic start_r;
  logic refused_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic acc;
  logic wr_en;
  logic go;
  logic go_ok;
  logic ref_clr;

  // pready comes one cycle into the access phase
  assign acc = psel & penable & ~pready_r;
  assign wr_en = psel & penable & pready_r & pwrite;
  assign go = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO];
  assign go_ok = go && state_r == HS_IDLE && prog_r <= PROG_MAX;
  assign ref_clr = wr_en && paddr == REG_STAT && pwdata[STAT_REFUSED];

  // apb answer registers; unmapped addresses report an error
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RESET_WORD;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && paddr != REG_CTRL && paddr != REG_PROG && paddr != REG_STAT;
      if (acc && !pwrite) begin
        prdata_r <= RESET_WORD;
        case (paddr)
          REG_CTRL: begin
            prdata_r[CTRL_IN3] <= in3_r;
            prdata_r[CTRL_ESTOP] <= estop_r;
          end
          REG_PROG: prdata_r[PROG_W-1:0] <= prog_r;
          REG_STAT: begin
            prdata_r[STAT_READY] <= link.ready;
            prdata_r[STAT_RUN] <= link.running;
            prdata_r[STAT_BUSY] <= (state_r != HS_IDLE);
            prdata_r[STAT_REFUSED] <= refused_r;
          end
          default: prdata_r <= RESET_WORD;
        endcase
      end
    end
  end

  // software-held levels and program number
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in3_r <= 1'b0;
      estop_r <= 1'b0;
      prog_r <= '0;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) begin
        in3_r <= pwdata[CTRL_IN3];
        estop_r <= pwdata[CTRL_ESTOP];
      end
      if (paddr == REG_PROG) begin
        prog_r <= pwdata[PROG_W-1:0];
      end
    end
  end

  // refused go is sticky; a new refusal beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= (go && !go_ok) || (refused_r && !ref_clr);
    end
  end

  // ready age, saturating; restarts whenever ready drops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_cnt_r <= '0;
    end else if (!link.ready) begin
      rdy_cnt_r <= '0;
    end else if (rdy_cnt_r != CNT_W'(RDY_CYC)) begin
      rdy_cnt_r <= rdy_cnt_r + 1'b1;
    end
  end

  // present number, wait both delays, then hold start for the width
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= HS_IDLE;
      cnt_r <= '0;
      bcd_r <= '0;
      start_r <= 1'b0;
    end else begin
      case (state_r)
        HS_IDLE: begin
          if (go_ok) begin
            bcd_r <= eps_bin_to_bcd(prog_r);
            cnt_r <= '0;
            state_r <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (cnt_r != CNT_W'(SEL_CYC)) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (rdy_cnt_r == CNT_W'(RDY_CYC)) begin
            start_r <= 1'b1;
            cnt_r <= '0;
            state_r <= HS_PULSE;
          end
        end
        HS_PULSE: begin
          if (cnt_r == CNT_W'(PULSE_CYC - 1)) begin
            start_r <= 1'b0;
            state_r <= HS_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= HS_IDLE;
          start_r <= 1'b0;
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link.start = start_r;
  assign link.gp_in3 = in3_r;
  assign link.estop = estop_r;
  assign link.prog_bcd = bcd_r;

endmodule
`default_nettype wire

// ===== tb/eps_link_assertions.sv
// timing and fault checks on the start link
`timescale 1ns/100ps
`default_nettype none
module eps_link_assertions
  import eps_pkg::*;
  #(
  parameter int RDY_CYC = 4,
  parameter int SEL_CYC = 8,
  parameter int PULSE_CYC = 6
  )
  (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ready,
  input wire logic running,
  input wire logic start,
  input wire logic gp_in3,
  input wire logic estop,
  input wire logic [BCD_W-1:0] prog_bcd
  );
  int rdy_n;
  int sel_n;
  int hi_n;
  logic [BCD_W-1:0] last_bcd;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // run lengths of ready, a steady number and start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_n <= 0;
      sel_n <= 0;
      hi_n <= 0;
      last_bcd <= '0;
    end else begin
      rdy_n <= ready ? rdy_n + 1 : 0;
      sel_n <= (prog_bcd == last_bcd) ? sel_n + 1 : 1; // first steady cycle counts
      hi_n <= start ? hi_n + 1 : 0;
      last_bcd <= prog_bcd;
    end
  end
  sequence s_req;
    $rose(start);
  endsequence
  sequence s_end;
    $fell(start);
  endsequence
  a_ready_to_start: assert property (s_req |-> rdy_n >= RDY_CYC)
    else $error("start raised too soon after ready");
  a_select_hold: assert property (s_req |-> sel_n >= SEL_CYC)
    else $error("start raised too soon after number");
  a_pulse_width: assert property (s_end |-> hi_n >= PULSE_CYC)
    else $error("start pulse too short");
  a_bcd_digits: assert property (s_req |-> prog_bcd[3:0] <= 4'h9 && prog_bcd[7:4] <= 4'h9
    && prog_bcd[11:8] <= 4'h9)
    else $error("non bcd number at start");
  a_number_steady: assert property (start && $past(start) |-> $stable(prog_bcd))
    else $error("number moved during start");
  a_estop_ready: assert property (estop |=> !ready)
    else $error("ready kept during emergency stop");
  a_estop_run: assert property (estop |=> !running)
    else $error("program kept running during stop");
  a_ready_idle: assert property (running |-> !ready)
    else $error("ready while a program runs");
endmodule
`default_nettype wire

// ===== tb/tb_external_program_start_interface.sv
// bench joining controller and sequencer ends, driven over apb
`timescale 1ns/100ps
`default_nettype none
module tb_external_program_start_interface;
  import eps_pkg::*;
  localparam int RC = 4;
  localparam int SC = 8;
  localparam int PC = 6;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] start_method = METHOD_AUTO;
  logic auto_mode = 1'b1;
  logic [PROG_W-1:0] auto_prog = 10'h07B;
  logic init_done = 1'b0;
  logic ctrl_error = 1'b0;
  logic prog_done = 1'b0;
  logic servo_on;
  logic ready_lamp;
  logic [PROG_W-1:0] disp_prog;
  logic run_prog;
  logic run_start;
  logic run_stop;
  logic start_ignored;
  logic bad_number;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  eps_link_if eps_link_if_i ();
  eps_device eps_device_i (.ref_clk(ref_clk), .rstn(rstn), .link(eps_link_if_i),
    .start_method(start_method), .auto_mode(auto_mode), .auto_prog(auto_prog),
    .init_done(init_done), .ctrl_error(ctrl_error), .prog_done(prog_done),
    .servo_on(servo_on), .ready_lamp(ready_lamp), .disp_prog(disp_prog), .run_prog(run_prog),
    .run_start(run_start), .run_stop(run_stop), .start_ignored(start_ignored),
    .bad_number(bad_number));
  eps_sequencer #(.RDY_CYC(RC), .SEL_CYC(SC), .PULSE_CYC(PC)) eps_sequencer_i (
    .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(eps_link_if_i));
  eps_link_assertions #(.RDY_CYC(RC), .SEL_CYC(SC), .PULSE_CYC(PC)) eps_link_assertions_i (
    .ref_clk(ref_clk), .rstn(rstn), .ready(eps_link_if_i.ready),
    .running(eps_link_if_i.running), .start(eps_link_if_i.start),
    .gp_in3(eps_link_if_i.gp_in3), .estop(eps_link_if_i.estop),
    .prog_bcd(eps_link_if_i.prog_bcd));
  // 40 mhz reference
  always #12.5 ref_clk = ~ref_clk;
  task wrap_up;
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_bit(input logic g, input logic e);
    cmp_word({31'h0000_0000, g}, {31'h0000_0000, e});
  endtask
  // one apb transfer; holds the request until pready is seen
  task apb_xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task apb_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask
  task apb_read(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0000_0000);
    cmp_word(rd, e);
  endtask
  // bounded wait for a start (0), stop (1) or ignored-request (2) pulse
  task wait_ev(input int k);
    int n;
    logic v;
    v = 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      #1;
      v = (k == 0) ? run_start : ((k == 1) ? run_stop : start_ignored);
      if (v === 1'b1) break;
    end
    cmp_bit(v, 1'b1);
  endtask
  task do_reset(input logic [1:0] m);
    rstn <= 1'b0;
    init_done <= 1'b0;
    start_method <= m;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task pdone;
    @(posedge ref_clk);
    prog_done <= 1'b1;
    @(posedge ref_clk);
    prog_done <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask
  initial begin
    // auto start once init_done is raised after reset
    do_reset(METHOD_AUTO);
    cmp_bit(eps_link_if_i.running, 1'b0);
    @(posedge ref_clk);
    init_done <= 1'b1;
    wait_ev(0);
    cmp_word(32'(disp_prog), 32'h0000_007B);
    apb_read(REG_STAT, 32'h0000_0002);
    pdone();
    $display("test auto start done");
    // external bcd selection then start
    do_reset(METHOD_EXT);
    @(posedge ref_clk);
    init_done <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_bit(ready_lamp, 1'b1);
    apb_read(REG_STAT, 32'h0000_0001);
    apb_write(REG_PROG, 32'h0000_01C8);
    apb_write(REG_CTRL, 32'h0000_0001);
    wait_ev(0);
    cmp_word(32'(disp_prog), 32'h0000_01C8);
    cmp_bit(run_prog, 1'b1);
    cmp_bit(bad_number, 1'b0);
    cmp_bit(ready_lamp, 1'b0);
    pdone();
    // out of range number is refused, sticky until cleared
    apb_write(REG_PROG, 32'h0000_03E8);
    apb_write(REG_CTRL, 32'h0000_0001);
    apb_read(REG_STAT, 32'h0000_0009);
    apb_write(REG_STAT, 32'h0000_0008);
    apb_read(REG_STAT, 32'h0000_0001);
    apb_read(8'h0C, 32'h0000_0000);
    cmp_bit(er, 1'b1);
    $display("test external start done");
    // input 3 edges start and stop
    start_method <= METHOD_EDGE;
    apb_write(REG_CTRL, 32'h0000_0002);
    wait_ev(0);
    cmp_word(32'(disp_prog), 32'h0000_01C8);
    apb_write(REG_CTRL, 32'h0000_0000);
    wait_ev(1);
    cmp_bit(eps_link_if_i.running, 1'b0);
    $display("test input edge done");
    // emergency stop while running, then controller error
    apb_write(REG_CTRL, 32'h0000_0002);
    wait_ev(0);
    apb_write(REG_CTRL, 32'h0000_0006);
    wait_ev(1);
    cmp_bit(servo_on, 1'b0);
    cmp_bit(ready_lamp, 1'b0);
    // input 3 rise while faulted must only be flagged
    apb_write(REG_CTRL, 32'h0000_0004);
    apb_write(REG_CTRL, 32'h0000_0006);
    wait_ev(2);
    apb_write(REG_CTRL, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_bit(servo_on, 1'b1);
    @(posedge ref_clk);
    ctrl_error <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_bit(servo_on, 1'b0);
    cmp_bit(eps_link_if_i.ready, 1'b0);
    @(posedge ref_clk);
    ctrl_error <= 1'b0;
    $display("test fault done");
    // method 1 outside automatic mode only waits in ready
    auto_mode <= 1'b0;
    do_reset(METHOD_AUTO);
    @(posedge ref_clk);
    init_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_bit(run_prog, 1'b0);
    cmp_bit(eps_link_if_i.ready, 1'b1);
    cmp_bit(ready_lamp, 1'b1);
    $display("test manual mode done");
    wrap_up();
  end
endmodule
`default_nettype wire
